// ### logic/blx_pkg.sv
// shared constants and types of the bit move instruction executor
package blx_pkg;

  // ----------------------------------------------------------------
  // instruction encoding
  // ----------------------------------------------------------------
  localparam logic [7:0] BLX_OPC_BIT_MOVE = 8'h47;
  localparam int BLX_INSTR_BYTES = 3;
  localparam int BLX_EXEC_CYCLES = 6;
  // second byte fields
  localparam int BLX_WREG_MSB = 7;
  localparam int BLX_WREG_LSB = 4;
  localparam int BLX_IDX_MSB = 3;
  localparam int BLX_IDX_LSB = 1;
  localparam int BLX_DIR_POS = 0;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] BLX_BYTE_RST = 8'h00;
  localparam logic [7:0] BLX_ADDR_RST = 8'h00;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    BLX_IDLE = 3'b000,
    BLX_GET2 = 3'b001,
    BLX_GET3 = 3'b010,
    BLX_RD_SRC = 3'b011,
    BLX_RD_DST = 3'b100,
    BLX_MERGE = 3'b101,
    BLX_WRITE = 3'b110
  } blx_state_t;

  typedef struct packed {
    logic rd_en;
    logic wr_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } blx_rf_req_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } blx_fetch_t;

  typedef struct packed {
    blx_state_t state;
    logic [7:0] byte2;
    logic [7:0] byte3;
    logic src_bit;
    blx_rf_req_t req;
    logic fetch_ready;
    logic busy;
    logic done;
  } blx_regs_t;

endpackage

// ### logic/blx_bit_move.sv
// bit move instruction executor between fetch stream and register file
`timescale 1ns/1ps
`default_nettype none

module blx_bit_move
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire blx_pkg::blx_fetch_t fetch,
  input wire logic [3:0] work_base,
  input wire logic [7:0] rf_rdata,
  output logic fetch_ready,
  output blx_pkg::blx_rf_req_t rf_req,
  output logic flag_write,
  output logic busy,
  output logic done
);
  import blx_pkg::*;

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync;
  logic rst_n;

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      rst_sync <= 2'h0;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];

  // ----------------------------------------------------------------
  // field decode
  // ----------------------------------------------------------------
  function automatic logic [7:0] work_addr(input logic [3:0] base,
                                           input logic [7:0] b2);
    work_addr = {base, b2[BLX_WREG_MSB:BLX_WREG_LSB]};
  endfunction

  function automatic logic [2:0] bit_index(input logic [7:0] b2);
    bit_index = b2[BLX_IDX_MSB:BLX_IDX_LSB];
  endfunction

  function automatic logic dir_of(input logic [7:0] b2);
    dir_of = b2[BLX_DIR_POS];
  endfunction

  // ----------------------------------------------------------------
  // state machine
  // ----------------------------------------------------------------
  blx_regs_t st;
  blx_regs_t next_st;
  logic dir;
  logic [2:0] idx;
  logic [7:0] wreg;

  assign dir = dir_of(st.byte2);
  assign idx = bit_index(st.byte2);
  assign wreg = work_addr(work_base, st.byte2);

  always_comb
  begin
    next_st = st;
    next_st.done = 1'b0;
    next_st.req.rd_en = 1'b0;
    next_st.req.wr_en = 1'b0;
    unique case (st.state)
      BLX_IDLE:
      begin
        // other opcodes belong to other decoders and pass by
        if (fetch.valid && fetch.data == BLX_OPC_BIT_MOVE)
        begin
          next_st.state = BLX_GET2;
          next_st.busy = 1'b1;
        end
      end
      BLX_GET2:
      begin
        if (fetch.valid)
        begin
          next_st.byte2 = fetch.data;
          next_st.state = BLX_GET3;
        end
      end
      BLX_GET3:
      begin
        if (fetch.valid)
        begin
          next_st.byte3 = fetch.data;
          next_st.state = BLX_RD_SRC;
          next_st.fetch_ready = 1'b0;
          next_st.req.rd_en = 1'b1;
          // source is the general register when direction is zero
          next_st.req.addr = dir ? wreg : fetch.data;
        end
      end
      BLX_RD_SRC:
      begin
        next_st.state = BLX_RD_DST;
        next_st.req.rd_en = 1'b1;
        next_st.req.addr = dir ? st.byte3 : wreg;
      end
      BLX_RD_DST:
      begin
        next_st.state = BLX_MERGE;
        next_st.src_bit = dir ? rf_rdata[0] : rf_rdata[idx];
      end
      BLX_MERGE:
      begin
        // read-modify-write: only the target bit may differ
        next_st.state = BLX_WRITE;
        next_st.req.wr_en = 1'b1;
        next_st.req.wdata = rf_rdata;
        if (dir)
          next_st.req.wdata[idx] = st.src_bit;
        else
          next_st.req.wdata[0] = st.src_bit;
      end
      BLX_WRITE:
      begin
        next_st.state = BLX_IDLE;
        next_st.busy = 1'b0;
        next_st.done = 1'b1;
        next_st.fetch_ready = 1'b1;
      end
      default:
      begin
        next_st.state = BLX_IDLE;
        next_st.busy = 1'b0;
        next_st.fetch_ready = 1'b1;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st.state <= BLX_IDLE;
      st.byte2 <= BLX_BYTE_RST;
      st.byte3 <= BLX_BYTE_RST;
      st.src_bit <= 1'b0;
      st.req <= '{rd_en: 1'b0, wr_en: 1'b0, addr: BLX_ADDR_RST,
                  wdata: BLX_BYTE_RST};
      st.fetch_ready <= 1'b1;
      st.busy <= 1'b0;
      st.done <= 1'b0;
    end
    else if (clk_en)
      st <= next_st;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  logic flag_write_q;

  // the flags register has no write path from this block
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      flag_write_q <= 1'b0;
    else
      flag_write_q <= 1'b0;
  end

  assign fetch_ready = st.fetch_ready;
  assign rf_req = st.req;
  assign flag_write = flag_write_q;
  assign busy = st.busy;
  assign done = st.done;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // a frozen write slot repeats, so only its first edge sees the merge
  a_dir0_merge: assert property (
    rf_req.wr_en && !dir && $past(st.state) == BLX_MERGE |->
      rf_req.wdata == {$past(rf_rdata[7:1]), st.src_bit})
    else $error("direction zero result wrong");

  a_dir1_merge: assert property (
    rf_req.wr_en && dir |-> rf_req.wdata[idx] == st.src_bit)
    else $error("direction one target bit wrong");

  a_others_kept: assert property (
    rf_req.wr_en && dir && $past(st.state) == BLX_MERGE |->
      ((rf_req.wdata ^ $past(rf_rdata)) & ~(8'h01 << idx)) == 8'h00)
    else $error("non target bit changed");

  a_write_dest: assert property (
    rf_req.wr_en |-> rf_req.addr == (dir ? st.byte3 : wreg))
    else $error("write not aimed at destination");

  a_flags_kept: assert property (
    !flag_write)
    else $error("flags written");

  a_src_addr: assert property (
    st.state == BLX_RD_SRC && !dir |->
      rf_req.rd_en && rf_req.addr == st.byte3)
    else $error("source address mis-decoded");

  a_dst_read: assert property (
    st.state == BLX_RD_DST |->
      rf_req.rd_en && rf_req.addr == (dir ? st.byte3 : wreg))
    else $error("destination read wrong");

  a_exec_span: assert property (
    st.state == BLX_RD_SRC && clk_en ##1 clk_en ##1 clk_en ##1 clk_en
      |=> done)
    else $error("execution length wrong");

  c_dir0: cover property (rf_req.wr_en && !dir);
  c_dir1: cover property (rf_req.wr_en && dir);
  c_stall: cover property (st.state == BLX_GET3 && !fetch.valid);
  c_freeze: cover property (rf_req.wr_en && !clk_en);

endmodule

`default_nettype wire

// ### tb/blx_bit_move_tb.sv
// self-checking bench of the bit move instruction executor
`timescale 1ns/1ps
`default_nettype none
module blx_bit_move_tb;
  import blx_pkg::*;
  logic sys_clk;
  logic reset_n;
  logic clk_en;
  logic fetch_ready;
  logic flag_write;
  logic busy;
  logic done;
  logic flag_seen;
  blx_fetch_t fetch;
  blx_rf_req_t rf_req;
  logic [3:0] work_base;
  logic [7:0] rf_rdata;
  logic [7:0] mem [256];
  int errors;
  int cmp_count;

  blx_bit_move u_dut (.sys_clk(sys_clk), .reset_n(reset_n),
    .clk_en(clk_en), .fetch(fetch), .work_base(work_base),
    .rf_rdata(rf_rdata), .fetch_ready(fetch_ready), .rf_req(rf_req),
    .flag_write(flag_write), .busy(busy), .done(done));

  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // ----------------------------------------------------------------
  // register file model
  // ----------------------------------------------------------------
  // idle read data toggles so a late capture never sees a stale match;
  // the file freezes with the core while the clock enable is low
  always @(posedge sys_clk)
  begin
    if (reset_n && clk_en)
    begin
      rf_rdata <= rf_req.rd_en ? mem[rf_req.addr] : ~rf_rdata;
      if (rf_req.wr_en)
        mem[rf_req.addr] <= rf_req.wdata;
    end
    // outputs are unknown until reset has reached them
    if (reset_n && flag_write !== 1'b0)
      flag_seen <= 1'b1;
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] seen, exp);
    cmp_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("counts: %0d compares, %0d errors", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // gap idle cycles go before byte two and byte three;
  // hold frozen cycles stretch the write slot
  task automatic run_op(input logic dir, input logic [3:0] wreg,
    input logic [2:0] idx, input logic [7:0] gaddr, input int gap,
    input int hold);
    logic [7:0] b [3];
    logic [7:0] waddr;
    logic [7:0] s0;
    logic [7:0] dexp;
    int k;
    int n;
    waddr = {work_base, wreg};
    b = '{BLX_OPC_BIT_MOVE, {wreg, idx, dir}, gaddr};
    s0 = dir ? mem[waddr] : mem[gaddr];
    dexp = dir ? mem[gaddr] : mem[waddr];
    if (dir)
      dexp[idx] = s0[0];
    else
      dexp[0] = s0[idx];
    n = 0;
    for (k = 0; k < 3; k++)
    begin
      if (k > 0)
        repeat (gap)
        begin
          fetch = '{1'b0, ~b[k]};
          @(negedge sys_clk);
          n++;
        end
      fetch = '{1'b1, b[k]};
      @(negedge sys_clk);
      n++;
    end
    fetch = '{1'b0, ~b[2]};
    while (rf_req.wr_en !== 1'b1 && n < 40)
    begin
      @(negedge sys_clk);
      n++;
    end
    check("write slot", 8'(n), 8'(6 + 2 * gap));
    check("ready busy", {6'h00, fetch_ready, busy}, 8'h01);
    if (hold > 0)
    begin
      clk_en = 1'b0;
      repeat (hold)
        @(negedge sys_clk);
      check("frozen", {6'h00, done, rf_req.wr_en}, 8'h01);
      clk_en = 1'b1;
    end
    @(negedge sys_clk);
    check("done", {7'h00, done}, 8'h01);
    check("idle again", {6'h00, fetch_ready, busy}, 8'h02);
    check("target", dir ? mem[gaddr] : mem[waddr], dexp);
    check("source", dir ? mem[waddr] : mem[gaddr], s0);
    check("flags", {7'h00, flag_seen}, 8'h00);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic test_dir0();
    for (int i = 0; i < 8; i++)
      run_op(1'b0, 4'h3, 3'(i), 8'h10 + 8'(i), 0, i % 3);
    $display("test dir0 done");
  endtask

  task automatic test_dir1();
    for (int i = 0; i < 8; i++)
      run_op(1'b1, 4'(i + 5), 3'(i), 8'h20 + 8'(i), i % 2, i % 3);
    $display("test dir1 done");
  endtask

  // a foreign opcode must start nothing
  task automatic test_ignore();
    logic seen;
    seen = 1'b0;
    fetch = '{1'b1, 8'h87};
    repeat (6)
    begin
      @(negedge sys_clk);
      fetch = '{1'b0, 8'h78};
      seen = seen | busy | rf_req.rd_en | rf_req.wr_en;
    end
    check("foreign op", {7'h00, seen}, 8'h00);
    $display("test ignore done");
  endtask

  initial
  begin
    reset_n = 1'b0;
    clk_en = 1'b1;
    fetch = '{1'b0, 8'h00};
    work_base = 4'hC;
    rf_rdata = 8'h00;
    flag_seen = 1'b0;
    errors = 0;
    cmp_count = 0;
    for (int i = 0; i < 256; i++)
      mem[i] = 8'(i) * 8'h3B ^ 8'h96;
    repeat (16) @(negedge sys_clk);
    reset_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    test_dir0();
    test_ignore();
    test_dir1();
    close_out();
  end

  // about sixty times the expected run length
  initial
  begin
    #50000;
    errors++;
    close_out();
  end
endmodule
`default_nettype wire
